/* include/two_wire_pkg.sv */
package two_wire_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    // System clock rate in hertz.
    localparam int CLOCK_HZ = 200_000_000;
    // Longest self-timed programming time, in microseconds.
    localparam int PROG_TIME_US = 5000;
    // Programming time in clock cycles, rounded down as a longest time.
    localparam int PROG_CYCLES = PROG_TIME_US * (CLOCK_HZ / 1_000_000);

    // ------------------------------------------------------------------
    // Array organisation
    // ------------------------------------------------------------------
    // Data word width in bits.
    localparam int DATA_W = 8;
    // Word address width: 1024 bytes in all.
    localparam int ADDR_W = 10;
    // Column address width: 16 bytes in one page.
    localparam int COL_W = 4;
    // Number of bytes in one page.
    localparam int PAGE_BYTES = 16;

    // ------------------------------------------------------------------
    // Protocol fields
    // ------------------------------------------------------------------
    // Fixed type code in the upper four bits of the device address.
    localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
    // Bit count at which a whole word has been shifted.
    localparam logic [3:0] BITS_WORD = 4'h8;
    // Bit count that marks the master acknowledge slot of a read.
    localparam logic [3:0] BITS_MACK = 4'h9;
    // Commit sweep count that ends the page copy.
    localparam logic [4:0] COMMIT_END = 5'h10;

    // Bus states, Gray coded along the write path.
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_DEV   = 3'h1,
        ST_WADDR = 3'h3,
        ST_WDATA = 3'h2,
        ST_RDATA = 3'h6
    } bus_state_e;
endpackage : two_wire_pkg

/* src/pin_sync.sv */
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Levels from outside the clock domain.
    input wire logic [W-1:0] i_async,
    // Levels safe to read.
    output logic [W-1:0] o_sync
);
    // First stage; read only by the second stage.
    logic [W-1:0] meta;

    // Two flip-flops per bit; reset to low, the level of a floating input.
    // floating strap reads low
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule : pin_sync

/* src/byte_store.sv */
module byte_store #(
    parameter int DW = 8,
    parameter int AW = 10
) (
    // Clock.
    input wire logic i_clock,
    // Write port.
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [DW-1:0] i_wr_data,
    // Read port; data one cycle after the address.
    input wire logic [AW-1:0] i_rd_addr,
    output logic [DW-1:0] o_rd_data
);
    // Storage words.
    logic [DW-1:0] store [0:(1<<AW)-1];

    // Write replaces the old word whole; read data leave a register.
    always_ff @(posedge i_clock) begin
        if (i_wr_en) begin
            store[i_wr_addr] <= i_wr_data;
        end
        o_rd_data <= store[i_rd_addr];
    end
endmodule : byte_store

/* src/two_wire_eeprom_bus_slave.sv */
// Overview of operation
// - Sample data on rise, drive on fall.
// - Data line is open drain only.
// - Unconnected chip select reads as low.
// - Lock input high blocks all programming.
// - Reads ignore the lock input level.
// - 1024 bytes, 64 pages of 16.
// - Start is data falling with clock high.
// - Stop ends command; read stop gives standby.
// - Write stop after a data byte starts programming, then standby.
// - Acknowledge each 8-bit word on ninth clock.
// - Standby after reset, read stop, programming.
// - Start, eighteen ones, start leaves the device awaiting an address.
// - Programming self-timed, at most 5 ms.
// - Page write up to 16 bytes, partial allowed.
// - Programming erases addressed locations by itself.
// - Serial clock up to 1 MHz supported.
// - Address 1010, chip select match, read bit.
// - No address acknowledge while programming.
// - Page write increments column bits only.
module two_wire_eeprom_bus_slave
    import two_wire_pkg::*;
#(
    parameter int PROG_CYCLES_P = PROG_CYCLES
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Serial bus pins.
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe_n,
    // Strap and protection pins.
    input wire logic i_chip_select_high_pin,
    input wire logic i_write_lock,
    // Status.
    output logic o_standby,
    output logic o_busy
);
    // ------------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------------
    // Width of the programming timer.
    localparam int PW = $clog2(PROG_CYCLES_P + 1);

    // Synchronised pin levels.
    logic scl_s;
    logic sda_s;
    logic cs_s;
    logic lock_s;
    // Previous sampled levels for edge detection.
    logic scl_d;
    logic sda_d;

    // Sampling at 200 MHz leaves ample margin on a 1 MHz serial clock.
    // fast clock sampling
    pin_sync #(
        .W(4)
    ) u_sync (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_async({i_scl, i_sda, i_chip_select_high_pin, i_write_lock}),
        .o_sync({scl_s, sda_s, cs_s, lock_s})
    );

    // Keep the last sampled levels.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_d <= 1'b0;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // ------------------------------------------------------------------
    // Edge and condition decode
    // ------------------------------------------------------------------
    // Clock edges, then start and stop conditions.
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_det = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_det = scl_s & scl_d & ~sda_d & sda_s;

    // Bus state and counters.
    bus_state_e state;
    // Bits shifted in the current word.
    logic [3:0] bit_cnt;
    // High while the device acknowledge slot runs.
    logic in_ack;
    // Receive shifter and transmit shifter.
    logic [7:0] shreg;
    logic [7:0] tx;
    // Current word address.
    logic [ADDR_W-1:0] ptr;
    // A data byte was taken in this write.
    logic got_data;
    // Master acknowledged the last read byte.
    logic mast_ack;
    // Programming in progress.
    logic busy;
    // Page copy sweep.
    logic commit;
    logic [4:0] commit_cnt;
    logic [COL_W-1:0] col_d;
    logic copy_d;
    // Programming timer.
    logic [PW-1:0] prog_cnt;
    // Columns loaded in the page buffer.
    logic [PAGE_BYTES-1:0] page_mask;
    // Array and page buffer read data.
    logic [7:0] mem_rdata;
    logic [7:0] page_rdata;

    // Receiving states.
    wire rx_state = (state == ST_DEV) | (state == ST_WADDR) | (state == ST_WDATA);
    wire dev_match = (shreg[7:4] == DEV_TYPE_CODE) & (shreg[3] == cs_s);
    wire accept = (state == ST_DEV) ? (dev_match & ~busy) : 1'b1;
    // Whole word received at the falling edge before the ninth clock.
    wire byte_done = scl_fall & rx_state & ~in_ack & (bit_cnt == BITS_WORD);
    // Falling edge that ends the device acknowledge.
    wire ack_end = scl_fall & in_ack;
    // Falling edge on which a read byte is loaded.
    wire rd_load = (ack_end & (state == ST_RDATA)) |
        (scl_fall & (state == ST_RDATA) & (bit_cnt == BITS_MACK) & mast_ack);
    wire page_we = byte_done & (state == ST_WDATA);
    wire [ADDR_W-1:0] ptr_col_inc = {ptr[ADDR_W-1:COL_W], ptr[COL_W-1:0] + 4'h1};
    wire prog_go = stop_det & (state == ST_WDATA) & got_data & ~lock_s;
    wire mem_we = copy_d & page_mask[col_d];
    wire [ADDR_W-1:0] mem_waddr = {ptr[ADDR_W-1:COL_W], col_d};

    // Open drain: only ever drives low.
    // open drain output
    assign o_sda = 1'b0;
    assign o_busy = busy;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // The 1024 byte array, read at the current address.
    // read ignores lock
    byte_store #(
        .DW(DATA_W),
        .AW(ADDR_W)
    ) u_array (
        .i_clock(i_clock),
        .i_wr_en(mem_we),
        .i_wr_addr(mem_waddr),
        .i_wr_data(page_rdata),
        .i_rd_addr(ptr),
        .o_rd_data(mem_rdata)
    );

    // The page buffer, filled during a write and copied at stop.
    byte_store #(
        .DW(DATA_W),
        .AW(COL_W)
    ) u_page (
        .i_clock(i_clock),
        .i_wr_en(page_we),
        .i_wr_addr(ptr[COL_W-1:0]),
        .i_wr_data(shreg),
        .i_rd_addr(commit_cnt[COL_W-1:0]),
        .o_rd_data(page_rdata)
    );

    // ------------------------------------------------------------------
    // Bus state machine
    // ------------------------------------------------------------------
    // Start and stop win over bit traffic; data move on clock edges.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            in_ack <= 1'b0;
            shreg <= 8'h00;
            tx <= 8'h00;
            ptr <= '0;
            got_data <= 1'b0;
            mast_ack <= 1'b0;
            o_sda_oe_n <= 1'b1;
        end else if (start_det) begin
            state <= ST_DEV;
            bit_cnt <= 4'h0;
            in_ack <= 1'b0;
            got_data <= 1'b0;
            o_sda_oe_n <= 1'b1;
        end else if (stop_det) begin
            state <= ST_IDLE;
            in_ack <= 1'b0;
            o_sda_oe_n <= 1'b1;
        end else if (scl_rise && rx_state && !in_ack && bit_cnt < BITS_WORD) begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
        end else if (byte_done && !accept) begin
            // Mismatch: leave the line released and wait for a start.
            state <= ST_IDLE;
        end else if (byte_done) begin
            in_ack <= 1'b1;
            o_sda_oe_n <= 1'b0;
            unique case (state)
                ST_DEV: begin
                    ptr[ADDR_W-1:ADDR_W-2] <= shreg[2:1];
                    state <= shreg[0] ? ST_RDATA : ST_WADDR;
                end
                ST_WADDR: begin
                    ptr[7:0] <= shreg;
                    state <= ST_WDATA;
                end
                default: begin
                    ptr <= ptr_col_inc;
                    got_data <= 1'b1;
                end
            endcase
        end else if (rd_load) begin
            tx <= mem_rdata;
            o_sda_oe_n <= mem_rdata[7];
            ptr <= ptr + 10'h001;
            bit_cnt <= 4'h0;
            in_ack <= 1'b0;
        end else if (ack_end) begin
            // Device acknowledge over; start the next received word.
            in_ack <= 1'b0;
            bit_cnt <= 4'h0;
            o_sda_oe_n <= 1'b1;
        end else if (state == ST_RDATA && scl_rise) begin
            // Count read bits; the ninth rise samples the master acknowledge.
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == BITS_WORD) begin
                mast_ack <= ~sda_s;
            end
        end else if (state == ST_RDATA && scl_fall) begin
            if (bit_cnt < BITS_WORD) begin
                // Next bit of the byte.
                tx <= {tx[6:0], 1'b0};
                o_sda_oe_n <= tx[6];
            end else if (bit_cnt == BITS_WORD) begin
                // Release for the master acknowledge.
                o_sda_oe_n <= 1'b1;
            end else begin
                // No acknowledge: wait for the stop in idle.
                state <= ST_IDLE;
                o_sda_oe_n <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Self-timed programming
    // ------------------------------------------------------------------
    // The timer spans the whole busy time, page copy included.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy <= 1'b0;
            prog_cnt <= '0;
        end else if (prog_go) begin
            busy <= 1'b1;
            prog_cnt <= '0;
        end else if (busy) begin
            prog_cnt <= prog_cnt + PW'(1);
            if (prog_cnt == PW'(PROG_CYCLES_P - 1)) begin
                busy <= 1'b0;
            end
        end
    end

    // Sweep the page buffer, one column per cycle.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            commit <= 1'b0;
            commit_cnt <= 5'h00;
            col_d <= '0;
            copy_d <= 1'b0;
        end else begin
            col_d <= commit_cnt[COL_W-1:0];
            copy_d <= commit;
            if (prog_go) begin
                commit <= 1'b1;
                commit_cnt <= 5'h00;
            end else if (commit) begin
                commit_cnt <= commit_cnt + 5'h01;
                commit <= (commit_cnt + 5'h01) != COMMIT_END;
            end
        end
    end

    // Loaded columns; cleared when a command is dropped or programmed.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            page_mask <= '0;
        end else if (page_we) begin
            page_mask[ptr[COL_W-1:0]] <= 1'b1;
        end else if ((start_det && !busy) || (busy && !commit && !copy_d)) begin
            page_mask <= '0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_standby <= 1'b1;
        end else begin
            o_standby <= (state == ST_IDLE) & ~busy;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    // Busy length counter for the programming bound.
    logic [PW:0] busy_len;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_len <= '0;
        end else begin
            busy_len <= busy ? busy_len + (PW+1)'(1) : '0;
        end
    end

    // Stop that starts no programming; every read stop is one of these.
    sequence s_read_stop;
        stop_det && !prog_go && !busy;
    endsequence
    // Accepted word at the ninth clock.
    sequence s_word_taken;
        byte_done && accept;
    endsequence

    no_idle_drive_a: assert property (!o_sda_oe_n |-> state != ST_IDLE)
        else $error("data line driven in idle");
    drive_on_fall_a: assert property ($changed(o_sda_oe_n) |->
        $past(scl_fall) || $past(start_det) || $past(stop_det))
        else $error("data line changed off a falling edge");
    sample_on_rise_a: assert property ($changed(shreg) |-> $past(scl_rise))
        else $error("shifter moved off a rising edge");
    ack_ninth_a: assert property (s_word_taken |=> !o_sda_oe_n && in_ack)
        else $error("accepted word not acknowledged");
    busy_nack_a: assert property (busy && state == ST_DEV |-> o_sda_oe_n)
        else $error("address acknowledged while programming");
    lock_blocks_a: assert property ($rose(busy) |-> $past(!lock_s))
        else $error("programming started while locked");
    prog_bound_a: assert property (busy_len <= (PW+1)'(PROG_CYCLES_P))
        else $error("programming ran too long");
    read_standby_a: assert property (s_read_stop |=> ##1 o_standby)
        else $error("no standby after read stop");
    column_wrap_a: assert property (page_we |=>
        ptr[ADDR_W-1:COL_W] == $past(ptr[ADDR_W-1:COL_W]) &&
        ptr[COL_W-1:0] == $past(ptr[COL_W-1:0]) + 4'h1)
        else $error("page write moved the row");
    start_restart_a: assert property (start_det |=> state == ST_DEV && bit_cnt == 4'h0)
        else $error("start did not restart the command");
endmodule : two_wire_eeprom_bus_slave

/* test/bus_master.sv */
module bus_master (
    // Clock and the resolved data line.
    input wire logic i_clock,
    input wire logic i_sda_line,
    // Pins driven by the master; a high drive lets the pull-up win.
    output logic o_scl,
    output logic o_sda_drive
);
    timeunit 1ns;
    timeprecision 100ps;
    // clock rate bound
    // Half serial period in system clocks, the nearest whole count to 24 ns.
    localparam int HALF = 5;

    // Bus idles with both lines released high.
    initial begin
        o_scl = 1'b1;
        o_sda_drive = 1'b1;
    end

    // Waits a number of system clock edges.
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
    endtask : tick

    // start framing
    // Data falls while the clock is high.
    task automatic send_start();
        tick(2);
        o_sda_drive <= 1'b1;
        tick(3);
        o_scl <= 1'b1;
        tick(HALF);
        o_sda_drive <= 1'b0;
        tick(HALF);
        o_scl <= 1'b0;
    endtask : send_start

    // stop framing
    // Data rises while the clock is high.
    task automatic send_stop();
        tick(2);
        o_sda_drive <= 1'b0;
        tick(3);
        o_scl <= 1'b1;
        tick(HALF);
        o_sda_drive <= 1'b1;
        tick(HALF);
    endtask : send_stop

    // data while low
    // Sets the bit in the low phase and samples the line late in the high phase.
    task automatic bit_io(input logic b, output logic r);
        tick(2);
        o_sda_drive <= b;
        tick(3);
        o_scl <= 1'b1;
        tick(HALF);
        r = i_sda_line;
        o_scl <= 1'b0;
    endtask : bit_io

    // eight bits ack
    // Sends a byte MSB first, then releases the line for the ninth clock.
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, ack);
    endtask : write_byte

    // Reads a byte MSB first, then answers with the given acknowledge level.
    task automatic read_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(nack, r);
    endtask : read_byte

    // recovery sequence
    // Start, eighteen released bits, then a second start.
    task automatic soft_reset();
        logic r;
        send_start();
        repeat (18) bit_io(1'b1, r);
        send_start();
    endtask : soft_reset
endmodule : bus_master

/* test/tb_two_wire_eeprom_bus_slave.sv */
module tb_two_wire_eeprom_bus_slave;
    import two_wire_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    // Short programming time so polling and waits stay brief.
    localparam int PROG = 400;

    // Bench drives and design outputs.
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic cs = 1'b0;
    logic lock = 1'b0;
    logic scl, drive, o_sda, oe_n, standby, busy, ack;
    logic [7:0] d;
    // Reference copy of the array, updated by the tasks below.
    logic [7:0] ref_mem [1024];
    int n_fail = 0;
    int total_checks = 0;
    int run = 0;
    int busy_len = 0;
    // Wired-AND data line with pull-up.
    wire sda_line = drive & (oe_n ? 1'b1 : o_sda);

    always #2.5 i_clock = ~i_clock;

    // Measures how long each programming pass keeps busy high.
    always @(posedge i_clock) begin
        if (busy === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            busy_len <= run;
            run <= 0;
        end
    end

    bus_master i_bus_master (.i_clock(i_clock), .i_sda_line(sda_line), .o_scl(scl),
        .o_sda_drive(drive));

    two_wire_eeprom_bus_slave #(.PROG_CYCLES_P(PROG)) i_two_wire_eeprom_bus_slave (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_line),
        .o_sda(o_sda), .o_sda_oe_n(oe_n), .i_chip_select_high_pin(cs),
        .i_write_lock(lock), .o_standby(standby), .o_busy(busy));

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    // Compares a seen value with the expected one.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Waits for busy to reach a level, counting a mismatch if it never does.
    task automatic wait_busy(input logic lvl, input int bound);
        int k;
        for (k = 0; k < bound && busy !== lvl; k++) begin
            @(posedge i_clock);
        end
        if (k == bound) begin
            n_fail++;
            test_done();
        end
    endtask : wait_busy

    // Sends the device address byte and checks its acknowledge.
    task automatic dev(input logic [9:0] a, input logic rw, input logic st, input logic exp);
        if (st) begin
            i_bus_master.send_start();
        end
        i_bus_master.write_byte({DEV_TYPE_CODE, cs, a[9:8], rw}, ack);
        check(16'(ack), 16'(exp));
    endtask : dev

    // Loads the word address with a write command.
    task automatic set_ptr(input logic [9:0] a, input logic st);
        dev(a, 1'b0, st, 1'b0);
        i_bus_master.write_byte(a[7:0], ack);
        check(16'(ack), 16'h0);
    endtask : set_ptr

    // Writes n bytes from base upward, then follows the programming pass.
    task automatic page_write(input logic [9:0] a, input int n, input logic [7:0] base);
        logic [3:0] col;
        set_ptr(a, 1'b1);
        for (int i = 0; i < n; i++) begin
            col = a[3:0] + 4'(i);
            i_bus_master.write_byte(base + 8'(i), ack);
            check(16'(ack), 16'h0);
            if (!lock) begin
                ref_mem[{a[9:4], col}] = base + 8'(i);
            end
        end
        i_bus_master.send_stop();
        if (lock) begin
            i_bus_master.tick(20);
            check(16'(busy), 16'h0);
        end else begin
            wait_busy(1'b1, 20);
            check(16'(standby), 16'h0);
            wait_busy(1'b0, PROG + 50);
            i_bus_master.tick(2);
            check(16'(busy_len <= PROG && busy_len + 2 >= PROG), 16'h1);
            check(16'(standby), 16'h1);
        end
    endtask : page_write

    // Random read of n bytes, nack on the last, compared with the reference.
    task automatic read_chk(input logic [9:0] a, input int n);
        set_ptr(a, 1'b1);
        dev(a, 1'b1, 1'b1, 1'b0);
        for (int i = 0; i < n; i++) begin
            i_bus_master.read_byte(i == n - 1, d);
            check(16'(d), 16'(ref_mem[a + 10'(i)]));
        end
        i_bus_master.send_stop();
        i_bus_master.tick(4);
        check(16'(standby), 16'h1);
    endtask : read_chk

    // Idle outputs after reset.
    task automatic t_reset();
        check({14'h0, oe_n, standby}, 16'h3);
        check(16'(busy), 16'h0);
        $display("test reset done");
    endtask : t_reset

    // Byte write, polling while busy, then read back.
    task automatic t_write_poll();
        page_write(10'h155, 1, 8'h5A);
        read_chk(10'h155, 1);
        set_ptr(10'h0A3, 1'b1);
        i_bus_master.write_byte(8'h11, ack);
        ref_mem[10'h0A3] = 8'h11;
        i_bus_master.send_stop();
        wait_busy(1'b1, 20);
        dev(10'h0, 1'b0, 1'b1, 1'b1);
        i_bus_master.send_stop();
        wait_busy(1'b0, PROG + 50);
        dev(10'h0, 1'b0, 1'b1, 1'b0);
        i_bus_master.send_stop();
        read_chk(10'h0A3, 1);
        $display("test write and poll done");
    endtask : t_write_poll

    // Page write past the page end, then reads across the top of the array.
    task automatic t_page();
        page_write(10'h20E, 18, 8'h30);
        read_chk(10'h200, 16);
        page_write(10'h000, 1, 8'h66);
        page_write(10'h3FF, 1, 8'h77);
        read_chk(10'h3FF, 2);
        $display("test page done");
    endtask : t_page

    // Locked write is acked but not stored; reads still work.
    task automatic t_lock();
        lock <= 1'b1;
        page_write(10'h155, 1, 8'hC3);
        read_chk(10'h155, 1);
        lock <= 1'b0;
        $display("test lock done");
    endtask : t_lock

    // Wrong type code and wrong chip select are refused.
    task automatic t_addr();
        i_bus_master.send_start();
        i_bus_master.write_byte(8'hB0, ack);
        check(16'(ack), 16'h1);
        i_bus_master.send_stop();
        i_bus_master.send_start();
        i_bus_master.write_byte(8'hA8, ack);
        check(16'(ack), 16'h1);
        i_bus_master.send_stop();
        cs <= 1'b1;
        read_chk(10'h155, 1);
        cs <= 1'b0;
        $display("test address done");
    endtask : t_addr

    // Transfer cut short, recovered with the soft reset sequence.
    task automatic t_soft();
        logic r;
        dev(10'h155, 1'b0, 1'b1, 1'b0);
        repeat (3) i_bus_master.bit_io(1'b0, r);
        i_bus_master.soft_reset();
        set_ptr(10'h155, 1'b0);
        i_bus_master.send_stop();
        read_chk(10'h155, 1);
        $display("test soft reset done");
    endtask : t_soft

    // Main sequence.
    initial begin
        repeat (16) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (8) @(posedge i_clock);
        t_reset();
        t_write_poll();
        t_page();
        t_lock();
        t_addr();
        t_soft();
        test_done();
    end
endmodule : tb_two_wire_eeprom_bus_slave
